/* rtl/serial_port_tx.v */
// Transmit side reset, rate generator, loopback and clock halt logic
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_tx_map.vh"
module serial_port_tx (
   input  wire        clk_sys,         // System clock 50 MHz
   input  wire        rst_n,           // Synchronous reset, low active
   input  wire [3:0]  address,         // Avalon word address
   input  wire        read,            // Avalon read strobe
   input  wire        write,           // Avalon write strobe
   input  wire [31:0] writedata,       // Avalon write data
   input  wire [3:0]  byteenable,      // Avalon byte enables
   output reg  [31:0] readdata,        // Avalon read data
   output reg         waitrequest,     // Avalon wait request
   output reg         irq,             // Level interrupt
   input  wire        rx_data_pin,     // External receive data
   input  wire        rx_frame_pin,    // External receive frame
   input  wire        rx_clock_pin,    // External receive clock
   output reg         tx_data_pin,     // Transmit data
   output reg         tx_frame_pin,    // Transmit frame
   output reg         tx_clock_pin,    // Transmit clock
   output reg         generated_clock, // Rate generator clock
   output reg         generated_frame_pulse, // Rate generator frame
   output reg         tx_ready_flag    // Transmit ready level
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Control words, data path state and synchronisers
   reg [15:0] ctrlOne;       // Control register one
   reg [15:0] ctrlTwo;       // Control register two
   reg [15:0] rateCfg;       // Divider and frame period
   reg [15:0] txShift;       // Transmit shift register
   reg [15:0] txHold;        // Transmit holding word
   reg        txHoldFull;    // Holding word waiting
   reg [15:0] rxShift;       // Receive shift register
   reg [15:0] rxData;        // Last received word
   reg [1:0]  irqStatus;     // Sticky events
   reg [1:0]  irqEnable;     // Event enables
   reg        softDisable;   // Rate gen left by software
   reg        txEnPrev;      // Last transmit enable
   reg [7:0]  divCnt;        // Clock divider counter
   reg [7:0]  perCnt;        // Frame period counter
   reg        frameEnPrev;   // Last frame logic state
   reg [3:0]  bitCnt;        // Bits remaining in word
   reg        busy;          // Word being sent
   reg        halfWait;      // Half cycle start delay
   reg [2:0]  rxDataSync;    // Receive data synchroniser
   reg [2:0]  rxFrameSync;   // Receive frame synchroniser
   reg [2:0]  rxClockSync;   // Receive clock synchroniser
   reg        rxClkPrev;     // Last effective receive clock
   reg        rxFrameSeen;   // Frame seen, first bit pending
   reg [4:0]  rxCount;       // Bits taken into current word
   // ---------------------------------------------------------------
   // Decoded control fields
   // ---------------------------------------------------------------
   // Software sees two control words and the rate config; these are their live decodes.
   // Loopback and clock halt both reroute the receive path, so they
   // are decoded side by side and read by the receiver.
   wire       loopback  = ctrlOne[`BIT_LOOPBACK];
   wire [1:0] haltSel   = ctrlOne[`BIT_HALT_HI:`BIT_HALT_LO];
   wire       haltMode  = haltSel[1];
   wire       haltDelay = haltSel[0];        // Half cycle start
   wire       frameEn   = ctrlTwo[`BIT_FRAME_EN];
   wire       rateEn    = ctrlTwo[`BIT_RATE_EN];
   wire       txEn      = ctrlTwo[`BIT_TX_EN];
   wire       rxEn      = ctrlOne[`BIT_RX_EN];
   wire [7:0] divVal    = rateCfg[`CFG_DIV_HI:`CFG_DIV_LO];
   wire [7:0] perVal    = rateCfg[`CFG_PER_HI:`CFG_PER_LO];
   // A write lands at the edge where waitrequest is seen low, the
   // same edge at which the master ends its request; a read is
   // registered one edge earlier so its data stand at that edge.
   wire       busWrite  = write & ~waitrequest; // Write lands now
   wire       busRead   = read & waitrequest;   // Read data prepared
   wire       divTick   = (divCnt == divVal);   // Half period done
   wire       clkRise   = divTick & ~generated_clock; // Rising edge
   wire       clkFall   = divTick & generated_clock;  // Falling edge
   wire       txWrite   = busWrite & (address == `ADDR_TX_DATA);
   wire       framePulse = rateEn & frameEn & clkRise &
                           (perCnt == `RST_BYTE);
   // Receive inputs: loopback feeds all three from transmit, halt mode only clock and frame
   wire       rxClkEff  = (loopback | haltMode) ? tx_clock_pin :
                          rxClockSync[2];
   wire       rxFrmEff  = (loopback | haltMode) ? tx_frame_pin :
                          rxFrameSync[2];
   wire       rxDatEff  = loopback ? tx_data_pin : rxDataSync[2];
   wire [15:0] be16     = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Three flops ahead of use; first stage read only by second
   // Pins are asynchronous to the system clock. Three stages keep
   // the pins equally delayed; only the last stage feeds logic, so
   // a metastable first stage never reaches a decision.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rxDataSync  <= 3'h0;
         rxFrameSync <= 3'h0;
         rxClockSync <= 3'h0;
      end else begin
         rxDataSync  <= {rxDataSync[1:0], rx_data_pin};
         rxFrameSync <= {rxFrameSync[1:0], rx_frame_pin};
         rxClockSync <= {rxClockSync[1:0], rx_clock_pin};
      end
   end
   // ---------------------------------------------------------------
   // Avalon slave and control registers
   // ---------------------------------------------------------------
   // One wait cycle on every access, then completion
   // Waitrequest idles high. A request seen with it high drops it
   // for one cycle; the next edge completes the access and raises
   // it again, so back to back requests each take two cycles.
   // Control and rate config writes honour the two low byte lanes only; other writes ignore byteenable.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata    <= `ZERO_WORD;
         ctrlOne     <= `RST_CTRL_ONE;
         ctrlTwo     <= `RST_CTRL_TWO;
         rateCfg     <= `RST_RATE_CFG;
         irqEnable   <= `RST_IRQ;
         softDisable <= 1'b0;
      end else begin
         waitrequest <= ~(read | write) | ~waitrequest;
         if (busWrite) begin
            case (address)
               `ADDR_CTRL_ONE: begin
                  ctrlOne <= (ctrlOne & ~be16) | (writedata[15:0] & be16);
               end
               `ADDR_CTRL_TWO: begin
                  // Separate resets per enable bit
                  ctrlTwo <= (ctrlTwo & ~be16) | (writedata[15:0] & be16);
                  if (byteenable[0] & rateEn & ~writedata[`BIT_RATE_EN]) begin
                     softDisable <= 1'b1;
                  end
               end
               `ADDR_RATE_CFG: begin
                  rateCfg <= (rateCfg & ~be16) | (writedata[15:0] & be16);
               end
               `ADDR_IRQ_ENABLE: begin
                  irqEnable <= writedata[1:0];
               end
               default: begin
                  // Other addresses store nothing
               end
            endcase
         end
         if (busRead) begin
            case (address)
               `ADDR_CTRL_ONE:   readdata <= {16'h0000, ctrlOne};
               `ADDR_CTRL_TWO:   readdata <= {16'h0000, ctrlTwo};
               `ADDR_RATE_CFG:   readdata <= {16'h0000, rateCfg};
               `ADDR_IRQ_STATUS: readdata <= {30'h00000000, irqStatus};
               `ADDR_IRQ_ENABLE: readdata <= {30'h00000000, irqEnable};
               `ADDR_RX_DATA:    readdata <= {16'h0000, rxData};
               default:          readdata <= `ZERO_WORD; // Unmapped
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // Sample rate generator
   // ---------------------------------------------------------------
   // Divider, period counter and frame pulse
   // While disabled the generator either toggles every cycle, the
   // state a chip reset leaves, or parks both outputs low once
   // software has switched it off. Enabled, the clock toggles each
   // time the divider reaches its programmed value, and the period
   // counter reloads whenever frame logic is switched on, so the
   // first frame pulse follows a full programmed period.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         divCnt                <= `RST_BYTE;
         perCnt                <= `RST_BYTE;
         frameEnPrev           <= 1'b0;
         generated_clock       <= 1'b0;
         generated_frame_pulse <= 1'b0;
      end else if (!rateEn) begin
         divCnt                <= `RST_BYTE;
         perCnt                <= perVal;
         frameEnPrev           <= frameEn;
         generated_frame_pulse <= 1'b0;
         // After chip reset clock toggles each cycle: cpu/2
         generated_clock <= softDisable ? 1'b0 : ~generated_clock;
      end else begin
         frameEnPrev <= frameEn;
         divCnt <= divTick ? `RST_BYTE : divCnt + `CNT_ONE;
         if (divTick) begin
            generated_clock <= ~generated_clock;
         end
         if (!frameEn) begin
            perCnt <= perVal;
         end else if (!frameEnPrev) begin
            perCnt <= perVal;
         end else if (clkRise) begin
            perCnt <= (perCnt == `RST_BYTE) ? perVal : perCnt - `CNT_ONE;
         end
         generated_frame_pulse <= framePulse;
      end
   end
   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   // Holds reset while disabled; shifts on generated clock
   // A written word waits in the holding register until a frame
   // pulse, or in clock halt mode a falling generated clock edge,
   // starts it. Bits leave most significant first and change on
   // falling generated clock edges, so the far side samples on the
   // rising edge. Ready drops on a data write and comes back as
   // soon as the holding register is free again.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         txShift       <= `RST_WORD;
         txHold        <= `RST_WORD;
         txHoldFull    <= 1'b0;
         txEnPrev      <= 1'b0;
         tx_ready_flag <= 1'b0;
         bitCnt        <= `BIT_CNT_ZERO;
         busy          <= 1'b0;
         halfWait      <= 1'b0;
         tx_data_pin   <= 1'b0;
         tx_frame_pin  <= 1'b0;
         tx_clock_pin  <= 1'b0;
      end else if (!txEn) begin
         txShift       <= `RST_WORD;
         txHoldFull    <= 1'b0;
         txEnPrev      <= 1'b0;
         tx_ready_flag <= 1'b0;
         busy          <= 1'b0;
         halfWait      <= 1'b0;
         tx_data_pin   <= 1'b0;
         tx_frame_pin  <= 1'b0;
         tx_clock_pin  <= 1'b0;
      end else begin
         txEnPrev <= 1'b1;
         // Ready rises on release, stays until a data write
         if (txWrite) begin
            tx_ready_flag <= 1'b0;
            txHold        <= writedata[15:0];
            txHoldFull    <= 1'b1;
         end else if (!txEnPrev) begin
            tx_ready_flag <= 1'b1;
         end
         tx_frame_pin <= 1'b0;
         if (!busy && txHoldFull && !txWrite &&
             (haltMode ? clkFall : framePulse)) begin
            txShift      <= txHold;
            txHoldFull   <= 1'b0;
            tx_ready_flag <= 1'b1;
            busy         <= 1'b1;
            halfWait     <= haltMode & haltDelay;
            bitCnt       <= `BIT_CNT_LAST;
            tx_frame_pin <= 1'b1;
            tx_data_pin  <= txHold[15];
         end else if (busy && clkFall) begin
            if (halfWait) begin
               halfWait <= 1'b0;
            end else if (bitCnt == `BIT_CNT_ZERO) begin
               busy <= 1'b0;
            end else begin
               bitCnt      <= bitCnt - 4'h1;
               txShift     <= {txShift[14:0], 1'b0};
               tx_data_pin <= txShift[14];
            end
         end
         // Halt mode: clock runs only during a word
         // Outside a word the clock pin parks low; with delay
         // selected the first half period is held back too.
         if (haltMode) begin
            tx_clock_pin <= (busy & ~halfWait) ? generated_clock : 1'b0;
         end else begin
            tx_clock_pin <= generated_clock;
         end
      end
   end
   // ---------------------------------------------------------------
   // Receiver and interrupts
   // ---------------------------------------------------------------
   // Samples effective receive data on clock rise
   // A frame seen since the last rise marks the next bit as the
   // first of a word and the sixteenth bit completes it. The frame
   // is remembered because it may end before the clock edge that
   // carries the first bit.
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rxShift     <= `RST_WORD;
         rxData      <= `RST_WORD;
         rxClkPrev   <= 1'b0;
         rxFrameSeen <= 1'b0;
         rxCount     <= `RX_CNT_ZERO;
         irqStatus   <= `RST_IRQ;
         irq         <= 1'b0;
      end else begin
         rxClkPrev <= rxClkEff;
         if (!rxEn) begin
            // Receiver held in reset
            rxShift     <= `RST_WORD;
            rxFrameSeen <= 1'b0;
            rxCount     <= `RX_CNT_ZERO;
         end else if (rxClkEff & ~rxClkPrev) begin
            rxShift     <= {rxShift[14:0], rxDatEff};
            rxFrameSeen <= 1'b0;
            if (rxFrameSeen | rxFrmEff) begin
               // First bit of a new word
               rxCount <= `RX_CNT_ONE;
            end else if (rxCount == `RX_CNT_LAST) begin
               // Sixteenth bit: word complete
               rxData  <= {rxShift[14:0], rxDatEff};
               rxCount <= `RX_CNT_ZERO;
            end else if (rxCount != `RX_CNT_ZERO) begin
               rxCount <= rxCount + `RX_CNT_ONE;
            end
         end else if (rxFrmEff) begin
            // Frame ahead of its first clock rise
            rxFrameSeen <= 1'b1;
         end
         // Bit 0 marks the transmitter leaving reset, bit 1 a frame
         // pulse; the interrupt follows status one cycle later.
         // Set beats clear in the same cycle
         irqStatus <= (irqStatus & ~((busWrite &&
                      address == `ADDR_IRQ_CLEAR) ? writedata[1:0] :
                      `RST_IRQ)) |
                      {framePulse, txEn & ~txEnPrev};
         irq <= |(irqStatus & irqEnable);
      end
   end
endmodule // serial_port_tx
`default_nettype wire

/* rtl/serial_port_tx_map.vh */
// Register map, field positions and reset values of the serial port control
`ifndef SERIAL_PORT_TX_MAP_VH
`define SERIAL_PORT_TX_MAP_VH
// ---------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------
`define ADDR_CTRL_ONE    4'h0
`define ADDR_CTRL_TWO    4'h1
`define ADDR_RATE_CFG    4'h2
`define ADDR_TX_DATA     4'h3
`define ADDR_IRQ_STATUS  4'h4
`define ADDR_IRQ_ENABLE  4'h5
`define ADDR_IRQ_CLEAR   4'h6
`define ADDR_RX_DATA     4'h7
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_LOOPBACK     15
`define BIT_HALT_HI      12
`define BIT_HALT_LO      11
`define BIT_FRAME_EN     7
`define BIT_RATE_EN      6
`define BIT_TX_EN        0
`define BIT_RX_EN        0
`define CFG_DIV_HI       7
`define CFG_DIV_LO       0
`define CFG_PER_HI       15
`define CFG_PER_LO       8
// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define RST_CTRL_ONE     16'h0000
`define RST_CTRL_TWO     16'h0000
`define RST_RATE_CFG     16'h0f01
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define RST_IRQ          2'h0
`define ZERO_WORD        32'h00000000
`define CNT_ONE          8'h01
`define BIT_CNT_ZERO     4'h0
`define BIT_CNT_LAST     4'hf
`define IRQ_TX_READY     0
`define IRQ_FRAME        1
`define RX_CNT_ZERO      5'h00
`define RX_CNT_ONE       5'h01
`define RX_CNT_LAST      5'h0f
`endif

/* tb/serial_port_tx_props.sv */
// Concurrent checks on the serial port control block ports
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_tx_map.vh"
module serial_port_tx_props (
   input wire logic        clk_sys,    // System clock
   input wire logic        rst_n,      // Sync reset, low active
   input wire logic [3:0]  address,    // Word address
   input wire logic        read,       // Read strobe
   input wire logic        write,      // Write strobe
   input wire logic [31:0] writedata,  // Write data
   input wire logic [3:0]  byteenable, // Byte lanes
   input wire logic        waitrequest,// Wait request
   input wire logic        generated_clock,       // Rate clock
   input wire logic        generated_frame_pulse, // Rate frame
   input wire logic        tx_ready_flag          // Ready level
);
   // ----------------------------------------
   // Shadow of control two enables
   // ----------------------------------------
   logic ctlWr;    // Control two write completes
   logic rateEn;   // Rate generator enabled
   logic frameEn;  // Frame logic enabled
   logic txEn;     // Transmitter enabled
   logic chipIdle; // Rate enable never set since reset
   assign ctlWr = write && !waitrequest && byteenable[0]
                  && address == `ADDR_CTRL_TWO;
   // Track enables as software writes them
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rateEn   <= 1'h0;
         frameEn  <= 1'h0;
         txEn     <= 1'h0;
         chipIdle <= 1'h1;
      end else if (ctlWr) begin
         rateEn   <= writedata[`BIT_RATE_EN];
         frameEn  <= writedata[`BIT_FRAME_EN];
         txEn     <= writedata[`BIT_TX_EN];
         chipIdle <= chipIdle & ~writedata[`BIT_RATE_EN];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_wait_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
   chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> !tx_ready_flag && !generated_frame_pulse)
      else $error("outputs active after reset");
   chk_half_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      chipIdle && $past(rst_n) |-> generated_clock != $past(generated_clock)
      && !generated_frame_pulse)
      else $error("clock not cpu half rate after reset");
   chk_rate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!chipIdle && !rateEn)[*3] |-> !generated_clock && !generated_frame_pulse)
      else $error("rate outputs active while disabled");
   chk_frame_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!frameEn)[*3] |-> !generated_frame_pulse)
      else $error("frame pulse with frame logic off");
   chk_ready_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctlWr && writedata[`BIT_TX_EN] && !txEn |-> ##[1:3] tx_ready_flag)
      else $error("ready not raised on enable");
   chk_ready_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_ready_flag && txEn && !(write && !waitrequest) |=> tx_ready_flag)
      else $error("ready dropped without data write");
   chk_tx_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!txEn)[*3] |-> !tx_ready_flag)
      else $error("ready while transmitter held in reset");
endmodule // serial_port_tx_props
bind serial_port_tx serial_port_tx_props chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable),
   .waitrequest(waitrequest), .generated_clock(generated_clock),
   .generated_frame_pulse(generated_frame_pulse),
   .tx_ready_flag(tx_ready_flag));
`default_nettype wire

/* tb/serial_codec_model.sv */
// External codec facing the serial pins
`timescale 1ns/100ps
`default_nettype none
module serial_codec_model (
   input  wire logic txClock, // Clock from the port
   input  wire logic txFrame, // Frame from the port
   input  wire logic txData,  // Data from the port
   output var  logic rxClock, // Clock back to the port
   output var  logic rxFrame, // Frame back to the port
   output var  logic rxData   // Data back to the port
);
   // Codec answers on the port's own clock and frame, data inverted
   // so a loopback path is told apart from the external one
   always @* begin
      rxClock = txClock;
      rxFrame = txFrame;
      rxData  = ~txData;
   end
endmodule // serial_codec_model
`default_nettype wire

/* tb/serial_port_tx_tb_top.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_tx_map.vh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   n_errors++; $display("Error %s expected %h got %h", nm, e, g); end end
module serial_port_tx_tb_top;
   logic        clk_sys = 1'h0, rst_n = 1'h0;  // Clock and reset
   logic [3:0]  address = 4'h0, byteenable = 4'h0; // Bus address, lanes
   logic        read = 1'h0, write = 1'h0;       // Bus strobes
   logic [31:0] writedata = 32'h0, readdata;     // Bus data
   logic        waitrequest, irq, rxD, rxF, rxC, txD, txF, txC;
   logic        genClk, genFrame, ready;         // Observed outputs
   logic [15:0] rd;                              // Last read value
   int          n_errors = 0, check_count = 0, i, k, rises;
   always #10 clk_sys = ~clk_sys;
   serial_port_tx dut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .rx_data_pin(rxD),
      .rx_frame_pin(rxF), .rx_clock_pin(rxC), .tx_data_pin(txD),
      .tx_frame_pin(txF), .tx_clock_pin(txC), .generated_clock(genClk),
      .generated_frame_pulse(genFrame), .tx_ready_flag(ready));
   serial_codec_model codec (.txClock(txC), .txFrame(txF), .txData(txD),
      .rxClock(rxC), .rxFrame(rxF), .rxData(rxD));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   // One access: hold until waitrequest is sampled low
   task automatic access(input logic wr, input logic [3:0] a,
                         input logic [15:0] d);
      int n;
      @(posedge clk_sys);
      address <= a; writedata <= {16'h0000, d}; byteenable <= 4'h3;
      write <= wr; read <= ~wr;
      n = 0;
      do begin @(posedge clk_sys); n++; end
      while (waitrequest !== 1'h0 && n < 50);
      if (n >= 50) n_errors++;
      rd = readdata[15:0]; // bench never sets reserved pin bits
      write <= 1'h0; read <= 1'h0;
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset values, unmapped read and cpu half rate clock
   task automatic test_reset;
      logic g0;
      access(0, `ADDR_CTRL_ONE, 16'h0); `CHECK("ctrl one", 16'h0000, rd)
      access(0, `ADDR_CTRL_TWO, 16'h0); `CHECK("ctrl two", 16'h0000, rd)
      access(0, `ADDR_RATE_CFG, 16'h0); `CHECK("rate cfg", 16'h0f01, rd)
      access(0, 4'hf, 16'h0); `CHECK("unmapped", 16'h0000, rd)
      @(posedge clk_sys); g0 = genClk;
      @(posedge clk_sys); `CHECK("half rate", ~g0, genClk)
   endtask
   // Loopback and clock halt fields write and read back
   task automatic test_modes;
      for (i = 0; i < 4; i++) begin
         access(1, `ADDR_CTRL_ONE, {1'h1, 2'h0, i[1:0], 11'h000});
         access(0, `ADDR_CTRL_ONE, 16'h0);
         `CHECK("mode fields", {1'h1, 2'h0, i[1:0], 11'h000}, rd)
      end
      access(1, `ADDR_CTRL_ONE, 16'h0000);
      access(0, `ADDR_CTRL_ONE, 16'h0); `CHECK("loop off", 16'h0000, rd)
   endtask
   // Ready level, its interrupt, masking and clearing
   task automatic test_ready;
      access(1, `ADDR_IRQ_ENABLE, 16'h0001); // before release
      access(1, `ADDR_CTRL_TWO, 16'h0001); wait_cycles(8);
      `CHECK("ready set", 1'h1, ready)
      `CHECK("irq set", 1'h1, irq)
      access(1, `ADDR_TX_DATA, 16'h1234); wait_cycles(2);
      `CHECK("ready cleared", 1'h0, ready)
      access(1, `ADDR_IRQ_CLEAR, 16'h0003); wait_cycles(2);
      `CHECK("irq cleared", 1'h0, irq)
      access(1, `ADDR_CTRL_TWO, 16'h0000); wait_cycles(4);
      `CHECK("ready off", 1'h0, ready)
      access(1, `ADDR_IRQ_ENABLE, 16'h0000);
      access(1, `ADDR_CTRL_TWO, 16'h0001); wait_cycles(4);
      `CHECK("irq masked", 1'h0, irq)
      access(1, `ADDR_CTRL_TWO, 16'h0000);
   endtask
   // Frame gating, first pulse spacing and software rate disable
   task automatic test_rate;
      logic pg;
      access(1, `ADDR_CTRL_TWO, 16'h0040);
      k = 0;
      repeat (200) begin @(posedge clk_sys); k += genFrame; end
      `CHECK("no frame", 0, k)
      access(1, `ADDR_CTRL_TWO, 16'h00c0);
      rises = 0; k = 0; pg = genClk;
      while (genFrame !== 1'h1 && k < 300) begin
         @(posedge clk_sys); k++;
         if (genClk === 1'h1 && pg === 1'h0) rises++;
         pg = genClk;
      end
      `CHECK("first frame", 1'h1, rises >= 15 && rises <= 17)
      access(1, `ADDR_CTRL_TWO, 16'h0000); wait_cycles(4);
      k = 0;
      repeat (40) begin @(posedge clk_sys); k += genClk | genFrame; end
      `CHECK("rate off", 0, k)
   endtask
   // Word sent with loopback on returns itself, off returns codec data
   task automatic test_loop;
      access(1, `ADDR_CTRL_TWO, 16'h00c1);
      for (i = 0; i < 2; i++) begin
         access(1, `ADDR_CTRL_ONE, {~i[0], 15'h0001});
         access(1, `ADDR_TX_DATA, 16'ha5c3); wait_cycles(400);
         access(0, `ADDR_RX_DATA, 16'h0);
         `CHECK("rx word", i ? 16'h5a3c : 16'ha5c3, rd)
      end
      // Clock halt without delay: clock parks low, receive tied
      access(1, `ADDR_CTRL_ONE, 16'h1001); wait_cycles(20);
      k = 0;
      repeat (40) begin @(posedge clk_sys); k += txC; end
      `CHECK("halt idle", 0, k)
      access(1, `ADDR_TX_DATA, 16'h3c5a); wait_cycles(200);
      access(0, `ADDR_RX_DATA, 16'h0);
      `CHECK("halt word", 16'hc3a5, rd)
      k = 0;
      repeat (40) begin @(posedge clk_sys); k += txC; end
      `CHECK("halt stop", 0, k)
   endtask
   // ----------------------------------------
   // Verdict
   // ----------------------------------------
   task automatic conclude;
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'h1;
      test_reset; test_modes; test_ready; test_rate; test_loop;
      conclude;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_errors++;
      conclude;
   end
endmodule // serial_port_tx_tb_top
`default_nettype wire
